/* wpd_regs.svh */
// offsets, field positions and timing constants of the wake pin detector
`ifndef WPD_REGS_SVH
`define WPD_REGS_SVH

// byte addresses of the registers
`define WPD_CTRL_ADDR 8'h00
`define WPD_STAT_ADDR 8'h04
`define WPD_MODE_ADDR 8'h08

// control register fields
`define WPD_CTRL_ENABLE 0
`define WPD_CTRL_MASK_RISE 1
`define WPD_CTRL_MASK_FALL 2
`define WPD_CTRL_WIDTH 3

// status register fields
`define WPD_STAT_LEVEL 0
`define WPD_STAT_FLAG0 1
`define WPD_STAT_FLAG1 2
`define WPD_STAT_SLEEP_BLOCK 3

// mode register field, a 3-bit chip mode
`define WPD_MODE_LSB 0
`define WPD_MODE_WIDTH 3

// filter time in ns; 10 us least, 25 us longest, 40 ns clock
`define WPD_FILTER_MIN_NS 10000
`define WPD_FILTER_MAX_NS 25000
`define WPD_CLK_NS 40

// axi responses
`define WPD_RESP_OKAY 2'h0
`define WPD_RESP_SLVERR 2'h2

`endif

/* wpd_pkg.sv */
// types shared by the wake pin detector files
package wpd_pkg;

    typedef enum logic [2:0] {
        WPD_MODE_NORMAL = 3'b000,
        WPD_MODE_STOP = 3'b001,
        WPD_MODE_SLEEP = 3'b010,
        WPD_MODE_RESTART = 3'b011,
        WPD_MODE_FAILSAFE = 3'b100,
        WPD_MODE_FLASH = 3'b101,
        WPD_MODE_OFF = 3'b110
    } wpd_mode_t;

endpackage

/* wpd_filter.sv */
// wake input synchroniser and persistence filter
`timescale 1ns/1ns
`default_nettype none
`include "wpd_regs.svh"

module wpd_filter #(
    parameter int COUNT = 250
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic wake_input,
    output logic level,
    output logic rise,
    output logic fall
);

    // ----------------------------------------
    // parameter check
    // ----------------------------------------
    if (COUNT < 2 || COUNT > 65535) begin : g_bad_count
        $error("wpd_filter: COUNT out of range");
    end

    // ----------------------------------------
    // synchroniser and counter
    // ----------------------------------------
    logic sync_a;
    logic sync_b;
    logic [15:0] count;
    logic [15:0] next_count;
    logic differs;
    logic done;

    localparam logic [15:0] LAST = 16'(COUNT - 1);

    assign differs = sync_b != level;
    // counter restarts whenever raw level equals the held level again
    assign done = differs && (count == LAST); // R12
    assign next_count = (!differs || done) ? 16'h0000
        : 16'(count + 16'h0001); // R12

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            count <= 16'h0000;
            level <= 1'b0;
            rise <= 1'b0;
            fall <= 1'b0;
        end else begin
            sync_a <= wake_input;
            sync_b <= sync_a;
            count <= next_count;
            if (done) begin
                level <= sync_b; // R02
            end
            rise <= done && sync_b; // R01
            fall <= done && !sync_b; // R01
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_short_pulse;
        @(posedge aclk) disable iff (!aresetn)
        $changed(level) |-> $past(differs, COUNT - 1);
    endproperty
    a_short_pulse: assert property (p_short_pulse) // R02
        else $error("level changed without persistence");

    property p_edge_level;
        @(posedge aclk) disable iff (!aresetn)
        (rise || fall) |-> (level == rise) && $changed(level);
    endproperty
    a_edge_level: assert property (p_edge_level) // R01
        else $error("edge pulse without level change");

endmodule
`default_nettype wire

/* wpd_top.sv */
// wake pin detector: filter, edge flags, wake requests, axi4-lite registers
// Summary of operation
// R01 - both rising and falling wake input transitions count as wake events
// R02 - a transition is accepted only after persisting the filter time
// R03 - software enables or disables wake detection by a control bit
// R04 - in off mode every wake event is ignored
// R05 - filtered level is readable in normal, stop and flash modes
// R06 - enabled, a qualified edge wakes the chip from sleep
// R07 - from fail-safe any qualified edge always requests restart
// R08 - enabled in normal, stop or flash, an edge sets its flag and irq
// R09 - rising and falling edge flags have independent interrupt masks
// R10 - a set flag when sleep is entered wakes the chip at once
// R11 - software clears both flags before commanding sleep
// R12 - filter counter restarts on raw change, qualifies at terminal count
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "wpd_regs.svh"

module wpd_top #(
    parameter int FILTER_COUNT =
        (`WPD_FILTER_MIN_NS + `WPD_CLK_NS - 1) / `WPD_CLK_NS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic wake_input,
    input wire logic [2:0] chip_mode,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wake_request,
    output logic restart_request,
    output logic wake_irq,
    output logic sleep_block
);

    // ----------------------------------------
    // parameter check
    // ----------------------------------------
    localparam int MAX_COUNT = `WPD_FILTER_MAX_NS / `WPD_CLK_NS;
    if (FILTER_COUNT < 2 || FILTER_COUNT > MAX_COUNT) begin : g_bad_filter
        $error("wpd_top: FILTER_COUNT out of range");
    end

    // ----------------------------------------
    // filter
    // ----------------------------------------
    logic level;
    logic rise;
    logic fall;

    wpd_filter #(
        .COUNT(FILTER_COUNT)
    ) u_filter (
        .aclk(aclk),
        .aresetn(aresetn),
        .wake_input(wake_input),
        .level(level),
        .rise(rise),
        .fall(fall)
    );

    // ----------------------------------------
    // mode decode
    // ----------------------------------------
    // chip mode comes from the mode controller on the same clock
    wpd_pkg::wpd_mode_t mode;
    logic in_awake;
    logic in_sleep;
    logic in_failsafe;
    logic in_off;
    logic any_edge;

    assign mode = wpd_pkg::wpd_mode_t'(chip_mode);
    assign in_awake = (mode == wpd_pkg::WPD_MODE_NORMAL)
        || (mode == wpd_pkg::WPD_MODE_STOP)
        || (mode == wpd_pkg::WPD_MODE_FLASH);
    assign in_sleep = mode == wpd_pkg::WPD_MODE_SLEEP;
    assign in_failsafe = mode == wpd_pkg::WPD_MODE_FAILSAFE;
    assign in_off = mode == wpd_pkg::WPD_MODE_OFF;
    assign any_edge = (rise || fall) && !in_off; // R04 R01

    // ----------------------------------------
    // control register
    // ----------------------------------------
    logic wake_input_enable;
    logic mask_rise;
    logic mask_fall;

    // ----------------------------------------
    // edge flags and wake requests
    // ----------------------------------------
    logic wake_edge_flag_0;
    logic wake_edge_flag_1;
    logic set_flag0;
    logic set_flag1;
    logic clr_flag0;
    logic clr_flag1;
    logic next_flag0;
    logic next_flag1;
    logic next_wake;
    logic next_restart;
    logic next_irq;
    logic flags_set;

    assign set_flag0 = wake_input_enable && in_awake && rise && !in_off; // R08
    assign set_flag1 = wake_input_enable && in_awake && fall && !in_off; // R08
    // set wins over a clear in the same cycle
    assign next_flag0 = set_flag0 || (wake_edge_flag_0 && !clr_flag0);
    assign next_flag1 = set_flag1 || (wake_edge_flag_1 && !clr_flag1);
    assign flags_set = wake_edge_flag_0 || wake_edge_flag_1;
    // a flag left set, or set while entering sleep, wakes at once
    assign next_wake = in_sleep
        && ((wake_input_enable && any_edge) || flags_set); // R06 R10
    assign next_restart = in_failsafe && any_edge; // R07
    assign next_irq = (wake_edge_flag_0 && !mask_rise)
        || (wake_edge_flag_1 && !mask_fall); // R08 R09

    // ----------------------------------------
    // axi4-lite write channel
    // ----------------------------------------
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_ok;

    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wr_ctrl = do_write && (aw_addr == `WPD_CTRL_ADDR) && w_strb[0];
    assign wr_stat = do_write && (aw_addr == `WPD_STAT_ADDR) && w_strb[0];
    assign wr_ok = (aw_addr == `WPD_CTRL_ADDR) || (aw_addr == `WPD_STAT_ADDR);
    // write one to clear
    assign clr_flag0 = wr_stat && w_data[`WPD_STAT_FLAG0]; // R11
    assign clr_flag1 = wr_stat && w_data[`WPD_STAT_FLAG1]; // R11

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `WPD_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr <= s_axi_awaddr;
                aw_held <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                w_held <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `WPD_RESP_OKAY : `WPD_RESP_SLVERR;
                aw_held <= 1'b0;
                w_held <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wake_input_enable <= 1'b0;
            mask_rise <= 1'b0;
            mask_fall <= 1'b0;
        end else if (wr_ctrl) begin
            wake_input_enable <= w_data[`WPD_CTRL_ENABLE]; // R03
            mask_rise <= w_data[`WPD_CTRL_MASK_RISE]; // R09
            mask_fall <= w_data[`WPD_CTRL_MASK_FALL]; // R09
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wake_edge_flag_0 <= 1'b0;
            wake_edge_flag_1 <= 1'b0;
            wake_request <= 1'b0;
            restart_request <= 1'b0;
            wake_irq <= 1'b0;
            sleep_block <= 1'b0;
        end else begin
            wake_edge_flag_0 <= next_flag0; // R08
            wake_edge_flag_1 <= next_flag1; // R08
            wake_request <= next_wake; // R06 R10
            restart_request <= next_restart; // R07
            wake_irq <= next_irq; // R08
            sleep_block <= next_flag0 || next_flag1; // R10
        end
    end

    // ----------------------------------------
    // axi4-lite read channel
    // ----------------------------------------
    logic [31:0] rd_word;
    logic rd_ok;
    logic level_shown;

    // the level reads as zero where the pin is not observable
    assign level_shown = in_awake && level; // R05
    assign rd_ok = (s_axi_araddr == `WPD_CTRL_ADDR)
        || (s_axi_araddr == `WPD_STAT_ADDR)
        || (s_axi_araddr == `WPD_MODE_ADDR);
    assign rd_word =
        (s_axi_araddr == `WPD_CTRL_ADDR) ?
            {29'h0, mask_fall, mask_rise, wake_input_enable} :
        (s_axi_araddr == `WPD_STAT_ADDR) ?
            {28'h0, sleep_block, wake_edge_flag_1, wake_edge_flag_0,
             level_shown} :
        (s_axi_araddr == `WPD_MODE_ADDR) ? {29'h0, chip_mode} :
        32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `WPD_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word; // R05
            s_axi_rresp <= rd_ok ? `WPD_RESP_OKAY : `WPD_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_off_ignored;
        @(posedge aclk) disable iff (!aresetn)
        in_off && !flags_set |=> !$rose(wake_edge_flag_0)
            && !restart_request;
    endproperty
    a_off_ignored: assert property (p_off_ignored) // R04
        else $error("wake event acted on in off mode");

    property p_disabled_no_flag;
        @(posedge aclk) disable iff (!aresetn)
        !wake_input_enable && !clr_flag0 |=> !$rose(wake_edge_flag_0);
    endproperty
    a_disabled_no_flag: assert property (p_disabled_no_flag) // R03
        else $error("flag set with detection disabled");

    property p_sleep_wake;
        @(posedge aclk) disable iff (!aresetn)
        in_sleep && wake_input_enable && (rise || fall) |=> wake_request;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake) // R06
        else $error("no wake from sleep on an edge");

    property p_failsafe_restart;
        @(posedge aclk) disable iff (!aresetn)
        in_failsafe && (rise || fall) |=> restart_request;
    endproperty
    a_failsafe_restart: assert property (p_failsafe_restart) // R07
        else $error("no restart from fail-safe on an edge");

    property p_flag_set;
        @(posedge aclk) disable iff (!aresetn)
        wake_input_enable && in_awake && rise |=> wake_edge_flag_0
            ##1 (wake_irq || mask_rise);
    endproperty
    a_flag_set: assert property (p_flag_set) // R08
        else $error("rising edge did not set its flag");

    property p_mask;
        @(posedge aclk) disable iff (!aresetn)
        wake_irq |-> $past(wake_edge_flag_0 && !mask_rise)
            || $past(wake_edge_flag_1 && !mask_fall);
    endproperty
    a_mask: assert property (p_mask) // R09
        else $error("interrupt raised from a masked flag");

    property p_flag_wakes_sleep;
        @(posedge aclk) disable iff (!aresetn)
        in_sleep && flags_set |=> wake_request;
    endproperty
    a_flag_wakes_sleep: assert property (p_flag_wakes_sleep) // R10
        else $error("pending flag did not wake from sleep");

    property p_level_read;
        @(posedge aclk) disable iff (!aresetn)
        in_awake |-> (rd_word[`WPD_STAT_LEVEL] == level)
            || (s_axi_araddr != `WPD_STAT_ADDR);
    endproperty
    a_level_read: assert property (p_level_read) // R05
        else $error("status does not show the filtered level");

endmodule
`default_nettype wire

/* wpd_wake_src.sv */
// behavioural wake switch that drives the raw wake pin
`timescale 1ns/1ns
`default_nettype none

module wpd_wake_src (
    input wire logic aclk,
    output logic wake_input
);
    initial wake_input = 1'b0;

    // pin is a plain level from a switch, changed just after an edge
    task automatic drive(input logic lvl, input int hold);
        wake_input <= lvl;
        repeat (hold) @(posedge aclk);
    endtask
endmodule

`default_nettype wire

/* wpd_top_test.sv */
// self-checking testbench of the wake pin detector
`timescale 1ns/1ns
`default_nettype none
`include "wpd_regs.svh"

module wpd_top_test;
    logic aclk, aresetn, wake_input;
    logic [2:0] chip_mode;
    logic [7:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic wake_request, restart_request, wake_irq, sleep_block;
    int errors, samples_checked;
    logic [31:0] d;
    logic [1:0] r;

    // ------------------------------------------------------------
    // clock, partner and design
    // ------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    wpd_wake_src u_src (.aclk(aclk), .wake_input(wake_input));

    // short filter keeps the run brief; timing below follows it
    wpd_top #(.FILTER_COUNT(4)) u_dut (
        .aclk(aclk), .aresetn(aresetn), .wake_input(wake_input),
        .chip_mode(chip_mode), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .wake_request(wake_request),
        .restart_request(restart_request), .wake_irq(wake_irq),
        .sleep_block(sleep_block)
    );

    // ------------------------------------------------------------
    // checking and bus tasks
    // ------------------------------------------------------------
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_up(input string what);
        errors++;
        $display("[ERR] %s expected answer seen timeout", what);
        test_done();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v,
                      output logic [1:0] resp);
        int n;
        n = 0;
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= v;
        wstrb <= 4'hf;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
            if (++n > 50) give_up("write");
        end
        resp = bresp;
        bready <= 1'b0;
        // one idle edge so a following call never re-drives ready at once
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v,
                      output logic [1:0] resp);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
            if (++n > 50) give_up("read");
        end
        v = rdata;
        resp = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic wr_ok(input logic [7:0] a, input logic [31:0] v);
        wr(a, v, r);
        check("bresp", r, `WPD_RESP_OKAY);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        rd(a, d, r);
        check("rdata", d, exp);
        check("rresp", r, `WPD_RESP_OKAY);
    endtask

    // edge-caused pulses are one cycle wide, so every cycle of the window is looked at
    task automatic watch(input int sel, input logic exp);
        logic seen;
        seen = 1'b0;
        repeat (40) begin
            @(posedge aclk);
            if ((sel == 0 ? wake_request : restart_request) === 1'b1)
                seen = 1'b1;
        end
        check(sel == 0 ? "wake_request" : "restart_request", seen, exp);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        errors = 0;
        samples_checked = 0;
        aresetn = 1'b0;
        chip_mode = wpd_pkg::WPD_MODE_NORMAL;
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check("wake_irq", wake_irq, 1'b0);
        rd_chk(`WPD_CTRL_ADDR, 32'h0);
        rd_chk(`WPD_STAT_ADDR, 32'h0);
        rd_chk(`WPD_MODE_ADDR, 32'h0);
        rd(8'h0c, d, r);
        check("unmapped rdata", d, 32'h0);
        check("unmapped rresp", r, `WPD_RESP_SLVERR);
        wr(8'h0c, 32'h7, r);
        check("unmapped bresp", r, `WPD_RESP_SLVERR);
        // detection off: level still tracks, no flags
        u_src.drive(1'b1, 20);
        chip_mode <= wpd_pkg::WPD_MODE_STOP;
        rd_chk(`WPD_STAT_ADDR, 32'h1);
        chip_mode <= wpd_pkg::WPD_MODE_FLASH;
        rd_chk(`WPD_STAT_ADDR, 32'h1);
        chip_mode <= wpd_pkg::WPD_MODE_NORMAL;
        u_src.drive(1'b0, 20);
        wr_ok(`WPD_CTRL_ADDR, 32'h1);
        u_src.drive(1'b1, 2);
        u_src.drive(1'b0, 20);
        rd_chk(`WPD_STAT_ADDR, 32'h0);
        u_src.drive(1'b1, 20);
        rd_chk(`WPD_STAT_ADDR, 32'hb);
        check("wake_irq", wake_irq, 1'b1);
        u_src.drive(1'b0, 20);
        rd_chk(`WPD_STAT_ADDR, 32'he);
        wr_ok(`WPD_STAT_ADDR, 32'h4);
        rd_chk(`WPD_STAT_ADDR, 32'ha);
        wr_ok(`WPD_CTRL_ADDR, 32'h3);
        repeat (3) @(posedge aclk);
        check("wake_irq", wake_irq, 1'b0);
        wr_ok(`WPD_CTRL_ADDR, 32'h5);
        repeat (3) @(posedge aclk);
        check("wake_irq", wake_irq, 1'b1);
        // pending flag at sleep entry wakes at once
        chip_mode <= wpd_pkg::WPD_MODE_SLEEP;
        watch(0, 1'b1);
        check("sleep_block", sleep_block, 1'b1);
        chip_mode <= wpd_pkg::WPD_MODE_NORMAL;
        wr_ok(`WPD_STAT_ADDR, 32'h6);
        rd_chk(`WPD_STAT_ADDR, 32'h0);
        chip_mode <= wpd_pkg::WPD_MODE_SLEEP;
        rd_chk(`WPD_MODE_ADDR, 32'(wpd_pkg::WPD_MODE_SLEEP));
        repeat (3) @(posedge aclk);
        u_src.drive(1'b1, 0);
        watch(0, 1'b1);
        u_src.drive(1'b0, 0);
        watch(0, 1'b1);
        wr_ok(`WPD_CTRL_ADDR, 32'h0);
        u_src.drive(1'b1, 0);
        watch(0, 1'b0);
        // fail-safe restarts even with detection off
        chip_mode <= wpd_pkg::WPD_MODE_FAILSAFE;
        u_src.drive(1'b0, 0);
        watch(1, 1'b1);
        u_src.drive(1'b1, 0);
        watch(1, 1'b1);
        wr_ok(`WPD_CTRL_ADDR, 32'h1);
        chip_mode <= wpd_pkg::WPD_MODE_OFF;
        u_src.drive(1'b0, 0);
        watch(0, 1'b0);
        check("sleep_block", sleep_block, 1'b0);
        // back in normal, the edge seen while off left no flag behind
        chip_mode <= wpd_pkg::WPD_MODE_NORMAL;
        rd_chk(`WPD_STAT_ADDR, 32'h0);
        test_done();
    end
endmodule

`default_nettype wire
